// file: dv/test_watchdog_with_powerup_delay.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module test_watchdog_with_powerup_delay;
  reg          clk, rst_n, cfg, slp, idl, pdx, wr_s, rd_s, rd_d;
  reg  [4:0]   ps;
  reg  [7:0]   addr;
  reg  [31:0]  wd, seed;
  wire [31:0]  rdata;
  wire         drst, wake, hold, irq;
  logic [31:0] q[$];
  bit          h;
  int          n_errors, total_checks, t;
  wdpu_top #(.OSC_DIV(32'd4), .TPU_CYC(32'd8)) dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .cfg_enable_in(cfg), .configured_postscaler_in(ps), .sleep_in(slp), .idle_in(idl),
    .powerdown_exit_in(pdx), .addr_in(addr), .wdata_in(wd), .wr_in(wr_s), .rd_in(rd_s),
    .rdata_out(rdata), .device_reset_out(drst), .wake_out(wake), .exec_hold_out(hold),
    .irq_out(irq));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function [31:0] nx(input [31:0] x);
    nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [31:0] cv(input on, input w);
    cv = {16'h0, on, 8'h0, ps, w, 1'b0};
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task ok;
    t++;
    $display("test %0d done", t);
  endtask
  task rst(input [4:0] p);
    rst_n <= 0;
    ps <= p;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    {addr, wd, wr_s} <= {a, d, 1'b1};
    @(posedge clk);
    wr_s <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clk);
    {addr, rd_s} <= {a, 1'b1};
    q.push_back(e);
    @(posedge clk);
    rd_s <= 0;
  endtask
  // Flags any pulse of reset (s=0) or wake (s=1) within n edges
  task wp(input bit s, input int n, output bit f);
    f = 0;
    repeat (n) begin
      @(posedge clk);
      if (s ? wake : drst) f = 1;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(rdata, q.pop_front());
    rd_d <= rd_s;
  end
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    {rst_n, cfg, slp, idl, pdx, wr_s, rd_s, rd_d} = 0;
    {ps, addr, wd} = 0;
    seed = 32'h140d4732;
    rst(5'h03);
    chk(hold, 1);
    rd(8'h00, cv(0, 0));
    repeat (10) @(posedge clk);
    chk(hold, 0);
    ok;
    seed = nx(seed);
    wr(8'h00, (seed | 32'h8002) & 32'hfffffffe);
    rd(8'h00, cv(1, 1));
    // One idle cycle follows the disabling write before the next access
    wr(8'h00, 32'h0);
    rd(8'h00, cv(0, 0));
    rd(8'h10, 32'h0);
    ok;
    wr(8'h00, 32'h8000);
    wp(0, 25, h);
    chk(h, 0);
    wp(0, 15, h);
    chk(h, 1);
    repeat (8) begin
      wr(8'h00, 32'h8001);
      wp(0, 8, h);
      chk(h, 0);
    end
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h1);
    chk(irq, 1);
    wr(8'h08, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    ok;
    wr(8'h00, 32'h8002);
    wr(8'h00, 32'h8003);
    wp(0, 3, h);
    chk(h, 1);
    rd(8'h04, 32'h4);
    wr(8'h00, 32'h0);
    slp <= 1;
    wr(8'h00, 32'h8000);
    wp(1, 45, h);
    chk(h, 1);
    wr(8'h00, 32'h0);
    slp <= 0;
    idl <= 1;
    wr(8'h00, 32'h8000);
    wp(1, 45, h);
    chk(h, 1);
    wr(8'h00, 32'h0);
    idl <= 0;
    ok;
    cfg <= 1;
    rd(8'h00, cv(1, 0));
    wr(8'h00, 32'h0);
    rd(8'h00, cv(1, 0));
    cfg <= 0;
    pdx <= 1;
    @(posedge clk);
    pdx <= 0;
    repeat (2) @(posedge clk);
    chk(hold, 1);
    repeat (12) @(posedge clk);
    chk(hold, 0);
    rst(5'h02);
    rd(8'h00, cv(0, 0));
    repeat (2) @(posedge clk);
    ok;
    report_and_stop;
  end
endmodule // test_watchdog_with_powerup_delay

// file: dv/wdpu_top_asserts.sv
`timescale 1ns/1ps
`include "wdpu_consts.vh"
// ****
// Port checks
// ****
module wdpu_asserts #(
  parameter [31:0] OSC_DIV = 32'd4,
  parameter [31:0] TPU_CYC = 32'd8
) (
  input wire        core_clk_in,
  input wire        rst_n_in,
  input wire        cfg_enable_in,
  input wire [4:0]  configured_postscaler_in,
  input wire        sleep_in,
  input wire        idle_in,
  input wire        powerdown_exit_in,
  input wire [7:0]  addr_in,
  input wire        rd_in,
  input wire [31:0] rdata_out,
  input wire        device_reset_out,
  input wire        wake_out,
  input wire        exec_hold_out
);
  reg [31:0] hcnt_reg;
  // Hold length is counted here; the repetition operator cannot take a parameter
  always @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) hcnt_reg <= 32'h0;
    else if (!exec_hold_out || powerdown_exit_in) hcnt_reg <= 32'h0;
    else hcnt_reg <= hcnt_reg + 32'h1;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd_ctrl; rd_in && addr_in == `WDPU_CTRL_OFS; endsequence
  sequence s_hold; exec_hold_out [*3]; endsequence
  property p_unimpl; s_rd_ctrl |=> rdata_out[31:16] == 16'h0 && rdata_out[14:7] == 8'h0
    && !rdata_out[0]; endproperty
  property p_on_cfg; s_rd_ctrl ##0 cfg_enable_in |=> rdata_out[15]; endproperty
  property p_ps; s_rd_ctrl |=> rdata_out[6:2] == $past(configured_postscaler_in); endproperty
  property p_idle_rd; !rd_in |=> rdata_out == 32'h0; endproperty
  property p_rst_pulse; device_reset_out |=> !device_reset_out; endproperty
  property p_wake; wake_out |-> $past(sleep_in || idle_in) ##1 !wake_out; endproperty
  property p_asleep; $past(sleep_in) && $past(sleep_in, 2) |-> !device_reset_out; endproperty
  property p_pd; powerdown_exit_in |-> ##2 s_hold; endproperty
  property p_hold_len; $fell(exec_hold_out) |-> hcnt_reg + 32'h2 >= TPU_CYC
    && hcnt_reg <= TPU_CYC + 32'h1; endproperty
  a_unimpl: assert property (p_unimpl) else $error("reserved bits set");
  a_on_cfg: assert property (p_on_cfg) else $error("enable bit low");
  a_ps: assert property (p_ps) else $error("shadow field wrong");
  a_idle_rd: assert property (p_idle_rd) else $error("read data without read");
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  a_asleep: assert property (p_asleep) else $error("reset while asleep");
  a_pd: assert property (p_pd) else $error("hold missing");
  a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
endmodule // wdpu_asserts
bind wdpu_top wdpu_asserts #(.OSC_DIV(OSC_DIV), .TPU_CYC(TPU_CYC)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cfg_enable_in(cfg_enable_in),
  .configured_postscaler_in(configured_postscaler_in), .sleep_in(sleep_in), .idle_in(idle_in),
  .powerdown_exit_in(powerdown_exit_in), .addr_in(addr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .device_reset_out(device_reset_out), .wake_out(wake_out),
  .exec_hold_out(exec_hold_out));

// file: hdl/wdpu_consts.vh
`ifndef WDPU_CONSTS_VH
`define WDPU_CONSTS_VH
// Register offsets (byte addresses, one aligned word each)
`define WDPU_CTRL_OFS       8'h00
`define WDPU_IRQ_STAT_OFS   8'h04
`define WDPU_IRQ_CLR_OFS    8'h08
`define WDPU_IRQ_EN_OFS     8'h0c
// Control register fields
`define WDPU_ON_BIT         15
`define WDPU_PS_HI          6
`define WDPU_PS_LO          2
`define WDPU_WIN_BIT        1
`define WDPU_CLR_BIT        0
// Interrupt status fields
`define WDPU_EV_TIMEOUT     0
`define WDPU_EV_WAKE        1
`define WDPU_EV_EARLY       2
`define WDPU_EV_W           3
// Reset values
`define WDPU_CTRL_RST       1'b0
`define WDPU_IRQ_EN_RST     3'h0
// Timing
`define WDPU_CLK_MHZ        100
`define WDPU_OSC_DIV        32'd3125
`define WDPU_TPU_US         32'd10
`define WDPU_TPU_CYC        (`WDPU_TPU_US * `WDPU_CLK_MHZ)
`define WDPU_CNT_W          32
`endif

// file: hdl/wdpu_osc_div.v
`timescale 1ns/1ps
// ****************************************
// Low-power oscillator tick divider
// ****************************************
module wdpu_osc_div #(
  parameter [31:0] DIV = 32'd3125
) (
  input  wire core_clk_in,
  input  wire rst_n_in,
  input  wire run_in,
  output reg  tick_out
);
  reg [31:0] cnt_reg;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg  <= 32'h0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_reg  <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_reg >= DIV - 32'd1) begin
      cnt_reg  <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 32'd1;
      tick_out <= 1'b0;
    end
  end
endmodule // wdpu_osc_div

// file: hdl/wdpu_top.v
`timescale 1ns/1ps
`include "wdpu_consts.vh"
// Notes on behaviour
// - When running, the timer counts low-power oscillator ticks and resets the device at timeout.
// - A timeout while asleep or idle wakes the device instead of resetting it.
// - Setting the enable bit 15 starts a timer not enabled by configuration; clearing it stops a software start.
// - The enable bit reads one whenever the timer runs, from configuration or software.
// - Bits 6 to 2 are read-only and reload from the configured postscaler on every reset; they set the timeout.
// - Bit 1 selects windowed operation when one and ordinary operation when zero.
// - Writing one to bit 0 restarts the count; writing zero does nothing.
// - Bits 31 to 16 and 14 to 7 read as zero and ignore writes.
// - After each power-down exit, code execution is held off for a fixed power-up delay; leaving sleep or idle does not hold it.
module wdpu_top #(
  parameter [31:0] OSC_DIV = `WDPU_OSC_DIV,
  parameter [31:0] TPU_CYC = `WDPU_TPU_CYC
) (
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire        cfg_enable_in,
  input  wire [4:0]  configured_postscaler_in,
  input  wire        sleep_in,
  input  wire        idle_in,
  input  wire        powerdown_exit_in,
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  output reg         device_reset_out,
  output reg         wake_out,
  output reg         exec_hold_out,
  output reg         irq_out
);
  // ****************************************
  // Registers
  // ****************************************
  reg                   sw_on_reg;
  reg                   win_reg;
  reg  [4:0]            postscaler_shadow_reg;
  reg                   ps_loaded_reg;
  reg  [`WDPU_CNT_W-1:0] count_reg;
  reg  [`WDPU_CNT_W-1:0] count_next;
  reg  [2:0]            irq_stat_reg;
  reg  [2:0]            irq_en_reg;
  reg  [31:0]           tpu_cnt_reg;
  reg  [31:0]           rdata_next;

  wire running = cfg_enable_in | sw_on_reg;
  wire osc_tick;

  function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  wire wr_ctrl = wr_in & sel(addr_in, `WDPU_CTRL_OFS);
  wire wr_clr  = wr_in & sel(addr_in, `WDPU_IRQ_CLR_OFS);
  wire wr_en   = wr_in & sel(addr_in, `WDPU_IRQ_EN_OFS);
  wire sw_clear = wr_ctrl & wdata_in[`WDPU_CLR_BIT];

  // Timeout is 2^ps ticks; window opens in the final quarter
  wire [`WDPU_CNT_W-1:0] limit  = {{(`WDPU_CNT_W-1){1'b0}}, 1'b1} << postscaler_shadow_reg;
  wire [`WDPU_CNT_W-1:0] win_lo = limit - (limit >> 2);
  wire timeout  = running & osc_tick & (count_reg >= limit - {{(`WDPU_CNT_W-1){1'b0}}, 1'b1});
  wire early    = running & sw_clear & win_reg & (count_reg < win_lo);
  wire asleep   = sleep_in | idle_in;

  // ****************************************
  // Oscillator tick
  // ****************************************
  wdpu_osc_div #(
    .DIV(OSC_DIV)
  ) u_osc (
    .core_clk_in(core_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (running),
    .tick_out   (osc_tick)
  );

  // ****************************************
  // Control register
  // ****************************************
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_on_reg             <= `WDPU_CTRL_RST;
      win_reg               <= `WDPU_CTRL_RST;
      postscaler_shadow_reg <= 5'h00;
      ps_loaded_reg         <= 1'b0;
    end else begin
      // Strap caught in the first cycle after release
      if (!ps_loaded_reg) begin
        postscaler_shadow_reg <= configured_postscaler_in;
        ps_loaded_reg         <= 1'b1;
      end
      if (wr_ctrl) begin
        sw_on_reg <= wdata_in[`WDPU_ON_BIT];
        win_reg   <= wdata_in[`WDPU_WIN_BIT];
      end
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  always @* begin
    count_next = count_reg;
    if (!running || sw_clear || timeout) begin
      count_next = {`WDPU_CNT_W{1'b0}};
    end else if (osc_tick) begin
      count_next = count_reg + {{(`WDPU_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg        <= {`WDPU_CNT_W{1'b0}};
      device_reset_out <= 1'b0;
      wake_out         <= 1'b0;
    end else begin
      count_reg        <= count_next;
      device_reset_out <= (timeout & ~asleep) | early;
      wake_out         <= timeout & asleep;
    end
  end

  // ****************************************
  // Power-up delay
  // ****************************************
  // Held from reset release and after each power-down exit
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tpu_cnt_reg   <= 32'h0;
      exec_hold_out <= 1'b1;
    end else if (powerdown_exit_in) begin
      tpu_cnt_reg   <= 32'h0;
      exec_hold_out <= 1'b1;
    end else if (exec_hold_out) begin
      if (tpu_cnt_reg >= TPU_CYC - 32'd1) begin
        exec_hold_out <= 1'b0;
      end else begin
        tpu_cnt_reg <= tpu_cnt_reg + 32'd1;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire [2:0] ev;
  assign ev[`WDPU_EV_TIMEOUT] = timeout;
  assign ev[`WDPU_EV_WAKE]    = timeout & asleep;
  assign ev[`WDPU_EV_EARLY]   = early;

  genvar i;
  generate
    for (i = 0; i < `WDPU_EV_W; i = i + 1) begin : g_stat
      // Set wins over a clear in the same cycle
      always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_stat_reg[i] <= 1'b0;
        end else if (ev[i]) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_clr && wdata_in[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_en_reg <= `WDPU_IRQ_EN_RST;
      irq_out    <= 1'b0;
    end else begin
      if (wr_en) begin
        irq_en_reg <= wdata_in[2:0];
      end
      irq_out <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // The clear bit reads zero; unused bits are never stored
  always @* begin
    rdata_next = 32'h0;
    case (addr_in)
      `WDPU_CTRL_OFS: begin
        rdata_next[`WDPU_ON_BIT] = running;
        rdata_next[`WDPU_PS_HI:`WDPU_PS_LO] = postscaler_shadow_reg;
        rdata_next[`WDPU_WIN_BIT] = win_reg;
      end
      `WDPU_IRQ_STAT_OFS: begin
        rdata_next[2:0] = irq_stat_reg;
      end
      `WDPU_IRQ_EN_OFS: begin
        rdata_next[2:0] = irq_en_reg;
      end
      default: begin
        rdata_next = 32'h0;
      end
    endcase
  end

  // A read right after disabling returns the new state; no stall needed
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h0;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= 32'h0;
    end
  end
endmodule // wdpu_top
